// ### include/core_sfr_pkg.sv
// Package for the core pointer, status and configuration register block.
package core_sfr_pkg;

  // ***********************************************************
  // Direct addresses in the special function register space
  // ***********************************************************
  localparam logic [7:0] ADDR_STACK_TOP_LOW = 8'h81;
  localparam logic [7:0] ADDR_POINTER_LOW_BYTE = 8'h82;
  localparam logic [7:0] ADDR_POINTER_HIGH_BYTE = 8'h83;
  localparam logic [7:0] ADDR_POINTER_PAGE_BYTE = 8'h84;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_CORE_CONFIGURATION = 8'haf;
  localparam logic [7:0] ADDR_STACK_TOP_HIGH = 8'hb7;
  localparam logic [7:0] ADDR_CPU_STATUS_WORD = 8'hd0;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [7:0] RST_STACK_TOP_LOW = 8'h07;
  localparam logic [2:0] RST_STACK_TOP_HIGH = 3'h0;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_CPU_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_CORE_CONFIGURATION = 8'h00;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int STATUS_CARRY = 7;
  localparam int STATUS_HALF_CARRY = 6;
  localparam int STATUS_USER_ZERO = 5;
  localparam int STATUS_BANK_HIGH = 4;
  localparam int STATUS_BANK_LOW = 3;
  localparam int STATUS_SIGNED_RANGE = 2;
  localparam int STATUS_USER_ONE = 1;
  localparam int STATUS_PARITY = 0;
  localparam int POWER_BAUD_DOUBLER = 7;
  localparam int POWER_SERIAL_WAKE = 6;
  localparam int POWER_IRQ_ZERO_WAKE = 5;
  localparam int POWER_STROBE_DISABLE = 4;
  localparam int POWER_SLEEP_REQUEST = 1;
  localparam int CONFIG_WIDE_STACK = 7;
  localparam int CONFIG_XDATA_MAP = 0;
  localparam logic [7:0] POWER_WRITE_MASK = 8'hfe;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'h81;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'hfe;
  localparam logic [23:0] XDATA_ONCHIP_LIMIT = 24'h0007ff;
  localparam logic [10:0] STACK_WIDE_STEP = 11'h001;

  // ***********************************************************
  // Carriers
  // ***********************************************************
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] high;
    logic [7:0] low;
  } data_pointer_type;

  typedef struct packed {
    data_pointer_type data_pointer;
    logic [7:0] stack_top_low;
    logic [2:0] stack_top_high;
    logic [7:0] cpu_status_word;
    logic [7:0] power_control;
    logic [7:0] core_configuration;
    logic [7:0] read_data;
    logic [10:0] push_address;
    logic push_valid;
    logic asleep;
    logic irq_zero_prev;
    logic strobe_enable;
    logic xdata_onchip;
    logic [1:0] bank;
  } core_state_type;

endpackage

// ### src/core_pointer_status_config.sv
// Core pointer, stack, status, power control and configuration registers.
`timescale 1ns/100ps

// Overview of operation
// - Data pointer held as page, high, low bytes.
// - Pointer increment carries into the page byte.
// - Push and call increment stack before writing.
// - Stack low byte resets to 07H.
// - Stack high byte low three bits extend pointer.
// - Stack high byte hidden while wide stack off.
// - Wide stack advances 00FFH to 0100H.
// - Narrow stack wraps FFH to 00H.
// - Status flags sit at fixed bit positions.
// - Status bits 4 and 3 select bank.
// - Power bit 7 doubles serial baud rate.
// - Power bit 6 lets serial interrupts wake.
// - Power bit 5 lets irq zero wake.
// - Power bit 4 stops the latch strobe.
// - Power bit 1 enters power-down.
// - Power bits 3,2 plain flags; bit 0 absent.
// - Configuration bits 6 to 1 are absent.
// - Configuration bit 0 maps on-chip memory low.
// - Configuration bit 0 clear routes data off chip.
// - Configuration resets to standard narrow behaviour.
// - Addresses above 0007FFH always go off chip.
// - Stack low byte lives at address 81H.
module core_pointer_status_config (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_pointer_inc,
  input wire logic i_stack_push,
  input wire logic i_stack_pop,
  input wire logic [7:0] i_accumulator,
  input wire logic i_flags_wr,
  input wire logic [7:0] i_flags_wdata,
  input wire logic i_serial_irq,
  input wire logic i_external_irq_zero_pin,
  input wire logic i_irq_zero_edge_mode,
  input wire logic i_xdata_access,
  output logic [7:0] o_sfr_rdata,
  output core_sfr_pkg::data_pointer_type o_data_pointer,
  output logic [10:0] o_stack_address,
  output logic o_push_write,
  output logic [7:0] o_cpu_status_word,
  output logic [1:0] o_bank_select,
  output logic o_baud_doubler,
  output logic o_latch_strobe_enable,
  output logic o_power_down,
  output logic o_onchip_xdata_select
);
  import core_sfr_pkg::*;

  core_state_type state_ff;
  core_state_type nxt_state;

  // ***********************************************************
  // Helpers
  // ***********************************************************
  function automatic logic [10:0] stack_step(input logic [10:0] sp, input logic wide, input logic up);
    logic [10:0] next_sp;
    next_sp = up ? sp + STACK_WIDE_STEP : sp - STACK_WIDE_STEP;
    // Without the wide stack only the low byte moves, so it wraps inside the 256-byte memory.
    if (!wide) begin
      next_sp = {sp[10:8], next_sp[7:0]};
    end
    return next_sp;
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  logic wide_now;
  logic [10:0] sp_now;
  logic irq_zero_wake;

  always_comb begin
    nxt_state = state_ff;
    wide_now = state_ff.core_configuration[CONFIG_WIDE_STACK];
    sp_now = {state_ff.stack_top_high, state_ff.stack_top_low};
    nxt_state.push_valid = 1'b0;

    // ***********************************************************
    // Software writes over direct addressing
    // ***********************************************************
    if (i_sfr_wr) begin
      if (hit(i_sfr_addr, ADDR_STACK_TOP_LOW)) begin
        nxt_state.stack_top_low = i_sfr_wdata;
      end
      if (hit(i_sfr_addr, ADDR_STACK_TOP_HIGH) && wide_now) begin
        nxt_state.stack_top_high = i_sfr_wdata[2:0];
      end
      if (hit(i_sfr_addr, ADDR_POINTER_LOW_BYTE)) begin
        nxt_state.data_pointer.low = i_sfr_wdata;
      end
      if (hit(i_sfr_addr, ADDR_POINTER_HIGH_BYTE)) begin
        nxt_state.data_pointer.high = i_sfr_wdata;
      end
      if (hit(i_sfr_addr, ADDR_POINTER_PAGE_BYTE)) begin
        nxt_state.data_pointer.page = i_sfr_wdata;
      end
      if (hit(i_sfr_addr, ADDR_POWER_CONTROL)) begin
        nxt_state.power_control = i_sfr_wdata & POWER_WRITE_MASK;
      end
      if (hit(i_sfr_addr, ADDR_CORE_CONFIGURATION)) begin
        nxt_state.core_configuration = i_sfr_wdata & CONFIG_WRITE_MASK;
      end
      if (hit(i_sfr_addr, ADDR_CPU_STATUS_WORD)) begin
        nxt_state.cpu_status_word[7:1] = i_sfr_wdata[7:1];
      end
    end

    // Flag updates from the execution unit win over a software write in the same cycle.
    if (i_flags_wr) begin
      nxt_state.cpu_status_word[7:1] = i_flags_wdata[7:1] & STATUS_WRITE_MASK[7:1];
    end
    nxt_state.cpu_status_word[STATUS_PARITY] = ^i_accumulator;

    // ***********************************************************
    // Pointer increment and stack movement
    // ***********************************************************
    if (i_pointer_inc) begin
      nxt_state.data_pointer = state_ff.data_pointer + 24'h000001;
    end

    if (i_stack_push) begin
      // The incremented pointer is both stored and used as the write address.
      {nxt_state.stack_top_high, nxt_state.stack_top_low} = stack_step(sp_now, wide_now, 1'b1);
      nxt_state.push_address = stack_step(sp_now, wide_now, 1'b1);
      nxt_state.push_valid = 1'b1;
    end else if (i_stack_pop) begin
      {nxt_state.stack_top_high, nxt_state.stack_top_low} = stack_step(sp_now, wide_now, 1'b0);
      nxt_state.push_address = sp_now;
    end else begin
      nxt_state.push_address = sp_now;
    end

    // ***********************************************************
    // Power-down entry and wake
    // ***********************************************************
    nxt_state.irq_zero_prev = i_external_irq_zero_pin;
    irq_zero_wake = i_irq_zero_edge_mode ? (state_ff.irq_zero_prev && !i_external_irq_zero_pin)
                                         : !i_external_irq_zero_pin;
    if (state_ff.power_control[POWER_SLEEP_REQUEST] && !state_ff.asleep) begin
      nxt_state.asleep = 1'b1;
    end else if (state_ff.asleep &&
                 ((state_ff.power_control[POWER_SERIAL_WAKE] && i_serial_irq) ||
                  (state_ff.power_control[POWER_IRQ_ZERO_WAKE] && irq_zero_wake))) begin
      nxt_state.asleep = 1'b0;
      nxt_state.power_control[POWER_SLEEP_REQUEST] = 1'b0;
    end

    nxt_state.strobe_enable = !nxt_state.power_control[POWER_STROBE_DISABLE];
    nxt_state.bank = {nxt_state.cpu_status_word[STATUS_BANK_HIGH],
                      nxt_state.cpu_status_word[STATUS_BANK_LOW]};

    // ***********************************************************
    // External data routing
    // ***********************************************************
    nxt_state.xdata_onchip = i_xdata_access &&
                             nxt_state.core_configuration[CONFIG_XDATA_MAP] &&
                             (nxt_state.data_pointer <= XDATA_ONCHIP_LIMIT);

    // ***********************************************************
    // Read data, registered; hidden and unmapped addresses read zero
    // ***********************************************************
    nxt_state.read_data = 8'h00;
    if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        ADDR_STACK_TOP_LOW: nxt_state.read_data = state_ff.stack_top_low;
        ADDR_STACK_TOP_HIGH: nxt_state.read_data = wide_now ? {5'h00, state_ff.stack_top_high} : 8'h00;
        ADDR_POINTER_LOW_BYTE: nxt_state.read_data = state_ff.data_pointer.low;
        ADDR_POINTER_HIGH_BYTE: nxt_state.read_data = state_ff.data_pointer.high;
        ADDR_POINTER_PAGE_BYTE: nxt_state.read_data = state_ff.data_pointer.page;
        ADDR_POWER_CONTROL: nxt_state.read_data = state_ff.power_control;
        ADDR_CORE_CONFIGURATION: nxt_state.read_data = state_ff.core_configuration;
        ADDR_CPU_STATUS_WORD: nxt_state.read_data = state_ff.cpu_status_word;
        default: nxt_state.read_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff.data_pointer <= {RST_POINTER, RST_POINTER, RST_POINTER};
      state_ff.stack_top_low <= RST_STACK_TOP_LOW;
      state_ff.stack_top_high <= RST_STACK_TOP_HIGH;
      state_ff.cpu_status_word <= RST_CPU_STATUS_WORD;
      state_ff.power_control <= RST_POWER_CONTROL;
      state_ff.core_configuration <= RST_CORE_CONFIGURATION;
      state_ff.read_data <= 8'h00;
      state_ff.push_address <= {RST_STACK_TOP_HIGH, RST_STACK_TOP_LOW};
      state_ff.push_valid <= 1'b0;
      state_ff.asleep <= 1'b0;
      state_ff.irq_zero_prev <= 1'b1;
      state_ff.strobe_enable <= 1'b1;
      state_ff.xdata_onchip <= 1'b0;
      state_ff.bank <= 2'h0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_sfr_rdata = state_ff.read_data;
  assign o_data_pointer = state_ff.data_pointer;
  assign o_stack_address = state_ff.push_address;
  assign o_push_write = state_ff.push_valid;
  assign o_cpu_status_word = state_ff.cpu_status_word;
  assign o_bank_select = state_ff.bank;
  assign o_baud_doubler = state_ff.power_control[POWER_BAUD_DOUBLER];
  assign o_latch_strobe_enable = state_ff.strobe_enable;
  assign o_power_down = state_ff.asleep;
  assign o_onchip_xdata_select = state_ff.xdata_onchip;

endmodule // core_pointer_status_config

// ### test/core_pointer_status_config_tb.sv
// Self-checking testbench for the core pointer, status and configuration registers.
`timescale 1ns/100ps
module core_pointer_status_config_tb;
  import core_sfr_pkg::*;
  logic i_mclk = 1'h0, i_resetn = 1'h0, i_sfr_wr = 1'h0, i_sfr_rd = 1'h0, i_pointer_inc = 1'h0;
  logic i_stack_push = 1'h0, i_stack_pop = 1'h0, i_flags_wr = 1'h0, i_serial_irq = 1'h0;
  logic i_external_irq_zero_pin = 1'h1, i_irq_zero_edge_mode = 1'h0, i_xdata_access = 1'h0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_accumulator = 8'h00, i_flags_wdata = 8'h00;
  logic [7:0] o_sfr_rdata, o_cpu_status_word, v;
  data_pointer_type o_data_pointer;
  logic [10:0] o_stack_address;
  logic [1:0] o_bank_select;
  logic o_push_write, o_baud_doubler, o_latch_strobe_enable, o_power_down, o_onchip_xdata_select;
  int failures = 0;
  int check_count = 0;
  always #4 i_mclk = ~i_mclk;
  core_pointer_status_config dut (.i_mclk, .i_resetn, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd,
    .i_pointer_inc, .i_stack_push, .i_stack_pop, .i_accumulator, .i_flags_wr, .i_flags_wdata, .i_serial_irq,
    .i_external_irq_zero_pin, .i_irq_zero_edge_mode, .i_xdata_access, .o_sfr_rdata, .o_data_pointer,
    .o_stack_address, .o_push_write, .o_cpu_status_word, .o_bank_select, .o_baud_doubler,
    .o_latch_strobe_enable, .o_power_down, .o_onchip_xdata_select);
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Every task starts and ends on a falling edge, so inputs never move near the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    pulse(i_sfr_wr);
  endtask
  task automatic rd(input logic [7:0] a);
    i_sfr_addr = a;
    pulse(i_sfr_rd);
    v = o_sfr_rdata;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    check("stack address", o_stack_address, 24'h7);
    rd(ADDR_STACK_TOP_LOW);
    check("stack low", v, 24'h07);
    rd(ADDR_CORE_CONFIGURATION);
    check("configuration", v, 24'h00);
  endtask
  task automatic t_pointer();
    wr(ADDR_POINTER_LOW_BYTE, 8'hff);
    wr(ADDR_POINTER_HIGH_BYTE, 8'hff);
    wr(ADDR_POINTER_PAGE_BYTE, 8'h12);
    check("pointer", o_data_pointer, 24'h12ffff);
    pulse(i_pointer_inc);
    check("pointer carry", o_data_pointer, 24'h130000);
    rd(ADDR_POINTER_PAGE_BYTE);
    check("page byte", v, 24'h13);
  endtask
  task automatic t_stack();
    wr(ADDR_STACK_TOP_LOW, 8'hfe);
    wr(ADDR_STACK_TOP_HIGH, 8'h05);
    rd(ADDR_STACK_TOP_HIGH);
    check("hidden high", v, 24'h00);
    pulse(i_stack_push);
    check("push address", o_stack_address, 24'h0ff);
    check("push write", o_push_write, 24'h1);
    pulse(i_stack_push);
    check("narrow wrap", o_stack_address, 24'h000);
    wr(ADDR_CORE_CONFIGURATION, 8'hff);
    rd(ADDR_CORE_CONFIGURATION);
    check("config mask", v, 24'h81);
    wr(ADDR_STACK_TOP_LOW, 8'hff);
    pulse(i_stack_push);
    check("wide carry", o_stack_address, 24'h100);
    wr(ADDR_STACK_TOP_HIGH, 8'h05);
    rd(ADDR_STACK_TOP_HIGH);
    check("wide high", v & 8'h07, 24'h05);
    check("wide address", o_stack_address, 24'h500);
    pulse(i_stack_pop);
    tick(1);
    check("pop address", o_stack_address, 24'h4ff);
    wr(ADDR_CORE_CONFIGURATION, 8'h00);
  endtask
  task automatic t_status();
    i_accumulator = 8'h03;
    wr(ADDR_CPU_STATUS_WORD, 8'hff);
    rd(ADDR_CPU_STATUS_WORD);
    check("status write", v, 24'hfe);
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_CPU_STATUS_WORD, 8'(b << 3));
      tick(1);
      check("bank", o_bank_select, 24'(b));
    end
    i_accumulator = 8'h00;
    i_flags_wdata = 8'h84;
    pulse(i_flags_wr);
    check("flags", o_cpu_status_word, 24'h84);
  endtask
  task automatic t_power();
    wr(ADDR_POWER_CONTROL, 8'h8d);
    rd(ADDR_POWER_CONTROL);
    check("power mask", v, 24'h8c);
    check("baud double", o_baud_doubler, 24'h1);
    wr(ADDR_POWER_CONTROL, 8'h10);
    tick(1);
    check("strobe off", o_latch_strobe_enable, 24'h0);
    check("baud normal", o_baud_doubler, 24'h0);
    i_external_irq_zero_pin = 1'h0;
    wr(ADDR_POWER_CONTROL, 8'h42);
    tick(2);
    check("asleep", o_power_down, 24'h1);
    pulse(i_serial_irq);
    check("serial wake", o_power_down, 24'h0);
    i_external_irq_zero_pin = 1'h1;
    for (int m = 0; m < 2; m++) begin
      i_irq_zero_edge_mode = 1'(m);
      wr(ADDR_POWER_CONTROL, 8'h22);
      tick(2);
      check("asleep", o_power_down, 24'h1);
      i_external_irq_zero_pin = 1'h0;
      tick(1);
      check("pin wake", o_power_down, 24'h0);
      i_external_irq_zero_pin = 1'h1;
    end
  endtask
  task automatic t_xdata();
    wr(ADDR_POINTER_PAGE_BYTE, 8'h00);
    wr(ADDR_POINTER_HIGH_BYTE, 8'h07);
    wr(ADDR_POINTER_LOW_BYTE, 8'hff);
    i_xdata_access = 1'h1;
    tick(2);
    check("off chip", o_onchip_xdata_select, 24'h0);
    wr(ADDR_CORE_CONFIGURATION, 8'h01);
    tick(1);
    check("on chip", o_onchip_xdata_select, 24'h1);
    pulse(i_pointer_inc);
    tick(1);
    check("above limit", o_onchip_xdata_select, 24'h0);
  endtask
  initial begin
    tick(4);
    i_resetn = 1'h1;
    t_reset();
    t_pointer();
    t_stack();
    t_status();
    t_power();
    t_xdata();
    test_done();
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule // core_pointer_status_config_tb

// ### test/core_sfr_asserts.sv
// Assertion checker for the core pointer, status and configuration registers.
`timescale 1ns/100ps
module core_sfr_asserts
  import core_sfr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_pointer_inc,
  input wire logic i_stack_push,
  input wire logic [7:0] i_accumulator,
  input wire logic i_xdata_access,
  input wire logic [7:0] o_sfr_rdata,
  input wire core_sfr_pkg::data_pointer_type o_data_pointer,
  input wire logic [10:0] o_stack_address,
  input wire logic o_push_write,
  input wire logic [7:0] o_cpu_status_word,
  input wire logic [1:0] o_bank_select,
  input wire logic o_latch_strobe_enable,
  input wire logic o_power_down,
  input wire logic o_onchip_xdata_select
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ****************
  // Properties
  // ****************
  push_write_a: assert property (i_stack_push |=> o_push_write) else $error("push gave no write");
  pointer_step_a: assert property (i_pointer_inc |=> o_data_pointer == $past(o_data_pointer) + 24'h000001)
    else $error("pointer increment wrong");
  strobe_off_a: assert property (i_sfr_wr && i_sfr_addr == ADDR_POWER_CONTROL && i_sfr_wdata[4] |=> ##1
    !o_latch_strobe_enable) else $error("strobe still enabled");
  sleep_entry_a: assert property (i_sfr_wr && i_sfr_addr == ADDR_POWER_CONTROL && i_sfr_wdata[1] && !o_power_down
    |-> ##2 o_power_down) else $error("no power down");
  bank_follow_a: assert property (o_bank_select == o_cpu_status_word[4:3]) else $error("bank mismatch");
  parity_track_a: assert property ($past(i_resetn) |-> o_cpu_status_word[0] == ^$past(i_accumulator))
    else $error("parity wrong");
  stack_reset_a: assert property (!$past(i_resetn) |-> o_stack_address == 11'h007) else $error("stack reset");
  power_bit0_a: assert property (i_sfr_rd && i_sfr_addr == ADDR_POWER_CONTROL |=> !o_sfr_rdata[0])
    else $error("power bit 0 read");
  config_gap_a: assert property (i_sfr_rd && i_sfr_addr == ADDR_CORE_CONFIGURATION |=> o_sfr_rdata[6:1] == 6'h00)
    else $error("config gap read");
  xdata_limit_a: assert property (o_onchip_xdata_select |-> $past(i_xdata_access) &&
    o_data_pointer <= XDATA_ONCHIP_LIMIT) else $error("onchip select wrong");
  cover property (i_stack_push ##1 o_push_write);
  cover property (o_power_down ##1 !o_power_down);
  cover property (o_onchip_xdata_select);
endmodule // core_sfr_asserts

bind core_pointer_status_config core_sfr_asserts chk (.i_mclk, .i_resetn, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata,
  .i_sfr_rd, .i_pointer_inc, .i_stack_push, .i_accumulator, .i_xdata_access, .o_sfr_rdata, .o_data_pointer,
  .o_stack_address, .o_push_write, .o_cpu_status_word, .o_bank_select, .o_latch_strobe_enable, .o_power_down,
  .o_onchip_xdata_select);
